// ---- hw/negotiation_tracker.sv ----
module negotiation_tracker (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // link status
    input  wire logic dl_down,
    input  wire logic fc_init2_exit,
    input  wire logic channel_disabled,
    // result
    output logic      pending
);
    vc0_regs_pkg::link_state_t state;
    vc0_regs_pkg::link_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            vc0_regs_pkg::LINK_DOWN: begin
                if (!dl_down) next_state = vc0_regs_pkg::LINK_INIT;
            end
            vc0_regs_pkg::LINK_INIT: begin
                if (fc_init2_exit) next_state = vc0_regs_pkg::LINK_UP;
            end
            vc0_regs_pkg::LINK_UP: begin
                next_state = vc0_regs_pkg::LINK_UP;
            end
            default: next_state = vc0_regs_pkg::LINK_DOWN;
        endcase
        if (dl_down || channel_disabled) next_state = vc0_regs_pkg::LINK_DOWN;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= vc0_regs_pkg::LINK_DOWN;
        end else begin
            state <= next_state;
        end
    end

    // pending unless flow-control init has completed
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pending <= 1'b1;
        end else begin
            pending <= (next_state != vc0_regs_pkg::LINK_UP);
        end
    end

    clear_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state == vc0_regs_pkg::LINK_INIT && fc_init2_exit && !dl_down && !channel_disabled) |=> !pending)
        else $error("pending not cleared after init exit");
    down_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        dl_down |=> pending)
        else $error("pending not set on link down");
endmodule : negotiation_tracker

// ---- hw/vc0_regs_pkg.sv ----
package vc0_regs_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0]  CTRL_OFFSET      = 8'h14;
    localparam logic [7:0]  STAT_OFFSET      = 8'h1a;
    // control fields
    localparam int          ENABLE_BIT       = 31;
    localparam int          ID_LSB           = 24;
    localparam int          ID_MSB           = 26;
    localparam int          PAS_LSB          = 17;
    localparam int          PAS_MSB          = 19;
    localparam int          MAP_LSB          = 1;
    localparam int          MAP_MSB          = 7;
    localparam int          CLASS0_BIT       = 0;
    // status fields
    localparam int          PENDING_BIT      = 1;
    // reset and fixed values
    localparam logic [31:0] CTRL_RESET       = 32'h800000ff;
    localparam logic [15:0] STAT_RESET       = 16'h0002;
    localparam logic [2:0]  PAS_RESET        = 3'h0;
    localparam logic [6:0]  MAP_RESET        = 7'h7f;
    localparam logic [2:0]  CHANNEL_ID       = 3'h0;
    localparam logic [7:0]  PORT_ARB_CAP     = 8'h01;

    // link flow-control phases
    typedef enum logic [2:0] {
        LINK_DOWN = 3'b001,
        LINK_INIT = 3'b010,
        LINK_UP   = 3'b100
    } link_state_t;
endpackage : vc0_regs_pkg

// ---- hw/vc0_resource_control_status.sv ----
module vc0_resource_control_status (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // register access
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [3:0]  reg_be,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // link status
    input  wire logic        dl_down,
    input  wire logic        fc_init2_exit,
    input  wire logic        channel_disabled,
    // channel configuration
    output logic      [2:0]  port_arbitration_select,
    output logic      [7:0]  traffic_class_channel_map,
    output logic      [7:0]  port_arbitration_capability,
    output logic             negotiation_pending
);
    ////////////////////////////////////////////////////////////////
    logic [31:0] control_word;
    logic [15:0] status_word;
    logic        pending;
    logic        ctrl_wr;
    logic        ctrl_hit;
    logic        stat_hit;
    logic        ctrl_rd;
    logic        stat_rd;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : merge_bytes

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction : reg_hit

    function automatic logic [31:0] control_image(input logic [2:0] sel, input logic [7:0] cls_map);
        logic [31:0] w;
        w = 32'h00000000;
        w[vc0_regs_pkg::ENABLE_BIT] = 1'b1;
        w[vc0_regs_pkg::ID_MSB:vc0_regs_pkg::ID_LSB] = vc0_regs_pkg::CHANNEL_ID;
        w[vc0_regs_pkg::PAS_MSB:vc0_regs_pkg::PAS_LSB] = sel;
        w[vc0_regs_pkg::MAP_MSB:vc0_regs_pkg::MAP_LSB] = cls_map[7:1];
        w[vc0_regs_pkg::CLASS0_BIT] = 1'b1;
        return w;
    endfunction : control_image

    assign ctrl_hit = reg_hit(reg_addr, vc0_regs_pkg::CTRL_OFFSET);
    assign stat_hit = reg_hit(reg_addr, vc0_regs_pkg::STAT_OFFSET);
    assign ctrl_wr  = reg_wr && ctrl_hit;
    assign ctrl_rd  = reg_rd && ctrl_hit;
    assign stat_rd  = reg_rd && stat_hit;

    ////////////////////////////////////////////////////////////////
    // writable control fields
    logic [31:0] merged;
    assign merged = merge_bytes(control_image(port_arbitration_select, traffic_class_channel_map),
                                reg_wdata, reg_be);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_arbitration_select <= vc0_regs_pkg::PAS_RESET;
        end else if (ctrl_wr) begin
            port_arbitration_select <= merged[vc0_regs_pkg::PAS_MSB:vc0_regs_pkg::PAS_LSB];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            traffic_class_channel_map <= {vc0_regs_pkg::MAP_RESET, 1'b1};
        end else if (ctrl_wr) begin
            // class zero forced on
            traffic_class_channel_map <= {merged[vc0_regs_pkg::MAP_MSB:vc0_regs_pkg::MAP_LSB], 1'b1};
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_arbitration_capability <= vc0_regs_pkg::PORT_ARB_CAP;
        end else begin
            port_arbitration_capability <= vc0_regs_pkg::PORT_ARB_CAP;
        end
    end

    ////////////////////////////////////////////////////////////////
    // negotiation tracking
    negotiation_tracker u_tracker (
        .ref_clk          (ref_clk),
        .nrst             (nrst),
        .dl_down          (dl_down),
        .fc_init2_exit    (fc_init2_exit),
        .channel_disabled (channel_disabled),
        .pending          (pending)
    );

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            negotiation_pending <= 1'b1;
        end else begin
            negotiation_pending <= pending;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path
    always_comb begin
        control_word = control_image(port_arbitration_select, traffic_class_channel_map);
        status_word = 16'h0000;
        status_word[vc0_regs_pkg::PENDING_BIT] = negotiation_pending;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
        end else if (ctrl_rd) begin
            reg_rdata <= control_word;
        end else if (stat_rd) begin
            reg_rdata <= {16'h0000, status_word};
        end else if (reg_rd) begin
            reg_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    enable_fixed_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_rd && reg_addr == vc0_regs_pkg::CTRL_OFFSET) |=> reg_rdata[31])
        else $error("channel enable read as zero");
    id_fixed_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_rd && reg_addr == vc0_regs_pkg::CTRL_OFFSET) |=> reg_rdata[26:24] == 3'h0)
        else $error("channel id not zero");
    select_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ctrl_wr && reg_be[2]) |=> port_arbitration_select == $past(reg_wdata[19:17]))
        else $error("arbitration select not written");
    map_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ctrl_wr && reg_be[0]) |=> traffic_class_channel_map == {$past(reg_wdata[7:1]), 1'b1})
        else $error("class map not written");
    class_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        traffic_class_channel_map[0])
        else $error("class zero unmapped");
    map_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !ctrl_wr |=> $stable(traffic_class_channel_map) && $stable(port_arbitration_select))
        else $error("control changed without write");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_rd && reg_addr == vc0_regs_pkg::CTRL_OFFSET) |=> reg_rdata[30:27] == 4'h0
            && reg_rdata[23:20] == 4'h0 && reg_rdata[16:8] == 9'h000)
        else $error("reserved control bits set");
    pending_link_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        dl_down |-> ##2 negotiation_pending)
        else $error("pending clear while link down");
    capability_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 port_arbitration_capability == 8'h01)
        else $error("capability not 01");

    ////////////////////////////////////////////////////////////////
    // read-back and byte-lane checks
    select_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctrl_rd |=> reg_rdata[19:17] == $past(port_arbitration_select))
        else $error("arbitration select read back wrong");
    map_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctrl_rd |=> reg_rdata[7:1] == $past(traffic_class_channel_map[7:1]))
        else $error("class map read back wrong");
    class_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctrl_rd |=> reg_rdata[0])
        else $error("class zero bit read as zero");
    select_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ctrl_wr && !reg_be[2]) |=> $stable(port_arbitration_select))
        else $error("select changed with lane disabled");
    map_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ctrl_wr && !reg_be[0]) |=> $stable(traffic_class_channel_map))
        else $error("class map changed with lane disabled");
    status_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_wr && stat_hit) |=> $stable(traffic_class_channel_map) && $stable(port_arbitration_select))
        else $error("status write changed control");
    unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_rd && !ctrl_hit && !stat_hit) |=> reg_rdata == 32'h00000000)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    enable_kept_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ctrl_wr && !reg_wdata[31]) ##[1:2] ctrl_rd |=> reg_rdata[31])
        else $error("channel enable cleared by write");

    ////////////////////////////////////////////////////////////////
    // status and link checks
    status_bit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        stat_rd |=> reg_rdata[1] == $past(negotiation_pending))
        else $error("pending flag read back wrong");
    status_reserved_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        stat_rd |=> reg_rdata[31:2] == 30'h00000000 && reg_rdata[0] == 1'b0)
        else $error("reserved status bits set");
    channel_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        channel_disabled |-> ##2 negotiation_pending)
        else $error("pending clear while channel disabled");
    cause_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dl_down || channel_disabled) |=> pending)
        else $error("tracker not pending after link cause");
    pending_rise_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(negotiation_pending) |-> $past(dl_down, 2) || $past(channel_disabled, 2))
        else $error("pending set without link cause");
    pending_fall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(negotiation_pending) |-> $past(fc_init2_exit, 2))
        else $error("pending cleared without init exit");
endmodule : vc0_resource_control_status

// ---- test/link_peer.sv ----
module link_peer (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // bench commands
    input  wire logic link_on,
    input  wire logic ch_off,
    // link status toward the block
    output logic      dl_down,
    output logic      fc_init2_exit,
    output logic      channel_disabled
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] step;

    ////////////////////////////////////////////////////////////////
    // link training, one exit pulse per bring-up
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dl_down          <= 1'b1;
            fc_init2_exit    <= 1'b0;
            channel_disabled <= 1'b0;
            step             <= 2'h0;
        end else begin
            dl_down          <= !link_on;
            channel_disabled <= ch_off;
            fc_init2_exit    <= (step == 2'h2);
            step             <= (!link_on || ch_off) ? 2'h0 : ((step == 2'h3) ? step : step + 2'h1);
        end
    end
endmodule : link_peer

// ---- test/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] ctrl_a = vc0_regs_pkg::CTRL_OFFSET;
    localparam logic [7:0] stat_a = vc0_regs_pkg::STAT_OFFSET;
    logic        ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, link_on = 0, ch_off = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [3:0]  reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        dl_down, fc_init2_exit, channel_disabled, negotiation_pending;
    logic [2:0]  port_arbitration_select;
    logic [7:0]  traffic_class_channel_map, port_arbitration_capability;
    int          n_mismatch = 0, compares = 0, cycles = 0;

    always #20 ref_clk = ~ref_clk;

    vc0_resource_control_status vc0_resource_control_status_i (.ref_clk(ref_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .dl_down(dl_down), .fc_init2_exit(fc_init2_exit),
        .channel_disabled(channel_disabled), .port_arbitration_select(port_arbitration_select),
        .traffic_class_channel_map(traffic_class_channel_map),
        .port_arbitration_capability(port_arbitration_capability), .negotiation_pending(negotiation_pending));
    link_peer link_peer_i (.ref_clk(ref_clk), .nrst(nrst), .link_on(link_on), .ch_off(ch_off),
        .dl_down(dl_down), .fc_init2_exit(fc_init2_exit), .channel_disabled(channel_disabled));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge ref_clk);
        {reg_addr, reg_be, reg_wdata, reg_wr} = {a, be, d, 1'b1};
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(negedge ref_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk(what, exp, reg_rdata);
    endtask : rd_chk
    task automatic wait_pend(input logic exp);
        for (int i = 0; i < 8 && negotiation_pending !== exp; i++) @(negedge ref_clk);
        chk("negotiation_pending", {31'h0, exp}, {31'h0, negotiation_pending});
    endtask : wait_pend
    task automatic tally_and_finish;
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        rd_chk("ctrl reset", ctrl_a, vc0_regs_pkg::CTRL_RESET);
        rd_chk("status reset", stat_a, {16'h0000, vc0_regs_pkg::STAT_RESET});
        chk("capability", 32'h01, {24'h0, port_arbitration_capability});
        chk("map reset", 32'hff, {24'h0, traffic_class_channel_map});
        wr(ctrl_a, 4'hf, 32'hffffffff);
        rd_chk("ctrl all ones", ctrl_a, 32'h800e00ff);
        chk("select", 32'h7, {29'h0, port_arbitration_select});
        wr(ctrl_a, 4'hf, 32'h00000000);
        rd_chk("ctrl all zeros", ctrl_a, 32'h80000001);
        chk("map cleared", 32'h01, {24'h0, traffic_class_channel_map});
        wr(ctrl_a, 4'h1, 32'hffff00aa);
        rd_chk("ctrl byte0", ctrl_a, 32'h800000ab);
        chk("map classes", 32'hab, {24'h0, traffic_class_channel_map});
        wr(ctrl_a, 4'h0, 32'hffffffff);
        rd_chk("ctrl no lanes", ctrl_a, 32'h800000ab);
        wr(stat_a, 4'hf, 32'h00000000);
        rd_chk("status write", stat_a, 32'h00000002);
        rd_chk("unmapped", 8'h40, 32'h00000000);
        link_on = 1'b1;
        wait_pend(1'b0);
        rd_chk("status done", stat_a, 32'h00000000);
        ch_off = 1'b1;
        wait_pend(1'b1);
        rd_chk("status disabled", stat_a, 32'h00000002);
        ch_off = 1'b0;
        wait_pend(1'b0);
        link_on = 1'b0;
        wait_pend(1'b1);
        link_on = 1'b1;
        wait_pend(1'b0);
        nrst = 1'b0;
        @(negedge ref_clk);
        chk("pending in reset", 32'h1, {31'h0, negotiation_pending});
        nrst = 1'b1;
        rd_chk("ctrl after reset", ctrl_a, 32'h800000ff);
        tally_and_finish();
    end
endmodule : testbench
